//--- src/alcivc_defs.svh
// Register offsets, gain codes, level thresholds and sample-period counts
`ifndef ALCIVC_DEFS_SVH
`define ALCIVC_DEFS_SVH

// Register offsets on the control write port
`define ALCIVC_LEFT_GAIN_ADDR 8'h09
`define ALCIVC_RIGHT_GAIN_ADDR 8'h0c

// Gain codes: 0.375 dB per code, mute at the bottom
`define ALCIVC_GAIN_RESET 8'he1
`define ALCIVC_GAIN_MAX 8'hf1
`define ALCIVC_GAIN_MIN 8'h01
`define ALCIVC_GAIN_MUTE 8'h00

// Shortest wait and timeout period, in sample periods
`define ALCIVC_BASE_PERIOD 15'h0080
`define ALCIVC_ZC_BASE_PERIOD 11'h080

// ADC initialisation cycle after power-up, in sample periods
`define ALCIVC_ADC_INIT_FS 10'h040

// Limiter detection levels as 16-bit sample magnitudes
`define ALCIVC_LEVEL_M2P5 16'h5ffd
`define ALCIVC_LEVEL_M4P1 16'h4fd6
`define ALCIVC_LEVEL_M6P0 16'h4027
`define ALCIVC_LEVEL_M8P5 16'h301b
`define ALCIVC_LEVEL_M12 16'h2027

`endif

//--- src/alcivc_pkg.sv
// Types shared by the level-control and input volume block
package alcivc_pkg;
	typedef enum logic [1:0] {ST_DOWN, ST_INIT, ST_MANUAL, ST_AUTO} alcivc_state_e;
	typedef logic [7:0] alcivc_gain_t;
	typedef logic [15:0] alcivc_sample_t;
endpackage

//--- src/alcivc_zero_cross.sv
// Per-channel zero-crossing detector with shared zero-crossing timeout counter
`timescale 1ns/10ps
`include "alcivc_defs.svh"
module alcivc_zero_cross (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Sample timing and control
	input wire logic fs_tick,
	input wire logic run,
	input wire logic restart,
	input wire logic [1:0] timeout_sel,
	// Channel sign bits
	input wire logic left_sign,
	input wire logic right_sign,
	// Events, valid on an fs tick
	output logic left_cross,
	output logic right_cross,
	output logic timeout
);
	logic [9:0] cnt;
	logic [9:0] next_cnt;
	logic prev_left;
	logic prev_right;
	logic next_prev_left;
	logic next_prev_right;
	logic [9:0] last;

	// Timeout counter and sign history; a restart drops any pending event
	always_comb begin
		last = 10'((`ALCIVC_ZC_BASE_PERIOD << timeout_sel) - 11'h001);
		next_cnt = cnt;
		next_prev_left = prev_left;
		next_prev_right = prev_right;
		left_cross = 1'b0;
		right_cross = 1'b0;
		timeout = 1'b0;
		if (!run || restart) begin
			next_cnt = 10'h000;
		end else if (fs_tick) begin
			left_cross = (left_sign != prev_left);
			right_cross = (right_sign != prev_right);
			timeout = (cnt == last);
			next_cnt = timeout ? 10'h000 : cnt + 10'h001;
		end
		if (fs_tick) begin
			next_prev_left = left_sign;
			next_prev_right = right_sign;
		end
	end

	// Register the counter and sign history
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= 10'h000;
			prev_left <= 1'b0;
			prev_right <= 1'b0;
		end else begin
			cnt <= next_cnt;
			prev_left <= next_prev_left;
			prev_right <= next_prev_right;
		end
	end
endmodule // alcivc_zero_cross

//--- src/alcivc_level_ctrl.sv
// Automatic level control and manual input volume for the recording path
`timescale 1ns/10ps
`include "alcivc_defs.svh"
// Function
// - Limiter hit on either channel lowers common gain by 1, 2, 4 or 8 steps; by 1 step each sample with zero cross disabled.
// - Recovery raises common gain by recovery step, at zero cross, capped at maximum.
// - Level between reset level and threshold clears the recovery wait timer.
// - Level below the reset level lets the recovery wait timer run.
// - After impulse noise recovery runs 4, 8 or 16 times faster; code 11 invalid.
// - Wait field selects 128 sample periods doubled per code, up to 16384.
// - Recovery gain field selects 1 to 4 steps of 0.375 dB.
// - Level control disabled means manual mode with programmed per-channel gains.
// - Manual gain changes apply at a zero crossing or on timeout.
// - Gains written while powered down apply after the ADC initialisation cycle.
// - Gain code F1 is +36 dB, 0.375 dB steps, 01 is -54, 00 mutes.
// - A changed gain write in manual mode restarts the zero-crossing counter.
// - A gain write equal to the previous one is ignored entirely.
// - On enable the left gain becomes the common start value.
// - Gain writes in level control do not apply until it is disabled.
module alcivc_level_ctrl (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Sample stream after the gain stage
	input wire logic fs_tick,
	input wire alcivc_pkg::alcivc_sample_t left_sample,
	input wire alcivc_pkg::alcivc_sample_t right_sample,
	// ADC power
	input wire logic left_adc_power,
	input wire logic right_adc_power,
	// Level-control configuration fields
	input wire logic auto_level_enable,
	input wire logic [1:0] limiter_threshold_sel,
	input wire logic [1:0] limiter_atten_step,
	input wire logic [2:0] recovery_wait_sel,
	input wire logic [1:0] zero_cross_timeout_sel,
	input wire logic [1:0] recovery_gain_step,
	input wire alcivc_pkg::alcivc_gain_t recovery_max_gain,
	input wire logic limiter_zero_cross_disable,
	input wire logic [1:0] fast_recovery_speed,
	// Register write and read port
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Applied gains and status
	output alcivc_pkg::alcivc_gain_t left_gain_applied,
	output alcivc_pkg::alcivc_gain_t right_gain_applied,
	output logic auto_active,
	output logic fast_recovery_active
);
	import alcivc_pkg::*;

	alcivc_state_e state, next_state;
	alcivc_gain_t left_input_gain, next_left_input_gain;
	alcivc_gain_t right_input_gain, next_right_input_gain;
	alcivc_gain_t tgt_l, next_tgt_l, tgt_r, next_tgt_r;
	alcivc_gain_t next_gl, next_gr;
	logic [14:0] wait_cnt, next_wait_cnt, wait_len;
	logic [9:0] init_cnt, next_init_cnt;
	logic fast, next_fast, hit, next_hit, next_auto_active;
	logic [7:0] next_rdata;
	logic adc_on, left_changed, right_changed, zc_restart, settled, running;
	logic cross_l, cross_r, zc_timeout;
	logic [15:0] peak;

	// Magnitude of a two's complement sample
	function automatic logic [15:0] mag(input logic [15:0] s);
		mag = s[15] ? (~s + 16'h0001) : s;
	endfunction

	// Limiter detection level and recovery-timer reset level per threshold code
	function automatic logic [15:0] level(input logic [1:0] sel, input logic lower);
		logic [2:0] idx;
		idx = {1'b0, sel} + {2'b00, lower};
		unique case (idx)
			3'h0: level = `ALCIVC_LEVEL_M2P5;
			3'h1: level = `ALCIVC_LEVEL_M4P1;
			3'h2: level = `ALCIVC_LEVEL_M6P0;
			3'h3: level = `ALCIVC_LEVEL_M8P5;
			default: level = `ALCIVC_LEVEL_M12;
		endcase
	endfunction

	// Limit to the top code; codes above it have no defined gain
	function automatic alcivc_gain_t clamp(input alcivc_gain_t g);
		clamp = (g > `ALCIVC_GAIN_MAX) ? `ALCIVC_GAIN_MAX : g;
	endfunction

	// Attenuate but never fall from an audible code into mute
	function automatic alcivc_gain_t atten(input alcivc_gain_t g, input logic [3:0] s);
		if (g == `ALCIVC_GAIN_MUTE)
			atten = `ALCIVC_GAIN_MUTE;
		else if (g > {4'h0, s})
			atten = g - {4'h0, s};
		else
			atten = `ALCIVC_GAIN_MIN;
	endfunction

	// Recover upward, stopping at the programmed maximum
	function automatic alcivc_gain_t recover(input alcivc_gain_t g, input alcivc_gain_t cap,
			input logic [1:0] s);
		logic [8:0] sum;
		sum = {1'b0, g} + {7'h00, s} + 9'h001;
		if (g >= clamp(cap))
			recover = g;
		else if (sum > {1'b0, clamp(cap)})
			recover = clamp(cap);
		else
			recover = sum[7:0];
	endfunction

	alcivc_zero_cross u_zero_cross (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.fs_tick(fs_tick),
		.run(running),
		.restart(zc_restart),
		.timeout_sel(zero_cross_timeout_sel),
		.left_sign(left_sample[15]),
		.right_sign(right_sample[15]),
		.left_cross(cross_l),
		.right_cross(cross_r),
		.timeout(zc_timeout)
	);

	// Shared decode; fast recovery shortens the wait, invalid code 11 acts as 4x
	always_comb begin
		adc_on = left_adc_power | right_adc_power;
		running = (state == ST_MANUAL) || (state == ST_AUTO);
		peak = (mag(left_sample) > mag(right_sample)) ? mag(left_sample) : mag(right_sample);
		settled = (left_gain_applied == tgt_l) && (right_gain_applied == tgt_r);
		wait_len = `ALCIVC_BASE_PERIOD << recovery_wait_sel;
		if (fast) begin
			unique case (fast_recovery_speed)
				2'b01: wait_len = wait_len >> 3;
				2'b10: wait_len = wait_len >> 4;
				default: wait_len = wait_len >> 2;
			endcase
		end
	end

	// Next-state logic for registers, targets, gains and timers
	always_comb begin
		next_state = state;
		next_tgt_l = tgt_l;
		next_tgt_r = tgt_r;
		next_gl = left_gain_applied;
		next_gr = right_gain_applied;
		next_wait_cnt = wait_cnt;
		next_init_cnt = init_cnt;
		next_fast = fast;
		next_hit = hit;
		zc_restart = 1'b0;
		// Same-value writes change nothing, not even the crossing counter
		left_changed = reg_wr && (reg_addr == `ALCIVC_LEFT_GAIN_ADDR) &&
			(reg_wdata != left_input_gain);
		right_changed = reg_wr && (reg_addr == `ALCIVC_RIGHT_GAIN_ADDR) &&
			(reg_wdata != right_input_gain);
		next_left_input_gain = left_changed ? reg_wdata : left_input_gain;
		next_right_input_gain = right_changed ? reg_wdata : right_input_gain;
		if (reg_addr == `ALCIVC_LEFT_GAIN_ADDR)
			next_rdata = left_input_gain;
		else if (reg_addr == `ALCIVC_RIGHT_GAIN_ADDR)
			next_rdata = right_input_gain;
		else
			next_rdata = 8'h00;
		// Each channel takes its target at its own crossing or on timeout
		if (running) begin
			if (cross_l || zc_timeout)
				next_gl = tgt_l;
			if (cross_r || zc_timeout)
				next_gr = tgt_r;
		end
		unique case (state)
			ST_DOWN: begin
				next_init_cnt = 10'h000;
				if (adc_on)
					next_state = ST_INIT;
			end
			ST_INIT: begin
				if (fs_tick && (init_cnt == `ALCIVC_ADC_INIT_FS - 10'h001)) begin
					// Powered-down writes take effect here, without waiting for a crossing
					next_tgt_l = clamp(left_input_gain);
					next_tgt_r = auto_level_enable ? clamp(left_input_gain) :
						clamp(right_input_gain);
					next_gl = next_tgt_l;
					next_gr = next_tgt_r;
					next_wait_cnt = 15'h0000;
					next_state = auto_level_enable ? ST_AUTO : ST_MANUAL;
				end else if (fs_tick) begin
					next_init_cnt = init_cnt + 10'h001;
				end
			end
			ST_MANUAL: begin
				next_tgt_l = clamp(next_left_input_gain);
				next_tgt_r = clamp(next_right_input_gain);
				if (left_changed || right_changed)
					zc_restart = 1'b1;
				if (auto_level_enable) begin
					next_state = ST_AUTO;
					next_tgt_l = clamp(left_input_gain);
					next_tgt_r = clamp(left_input_gain);
					next_wait_cnt = 15'h0000;
					next_fast = 1'b0;
					next_hit = 1'b0;
					zc_restart = 1'b1;
				end
			end
			ST_AUTO: begin
				if (!auto_level_enable) begin
					// Writes held back during level control now take over
					next_state = ST_MANUAL;
					next_tgt_l = clamp(left_input_gain);
					next_tgt_r = clamp(right_input_gain);
					next_fast = 1'b0;
					zc_restart = 1'b1;
				end else if (fs_tick) begin
					next_hit = 1'b0;
					if (peak >= level(limiter_threshold_sel, 1'b0)) begin
						next_wait_cnt = 15'h0000;
						next_hit = 1'b1;
						next_fast = 1'b0;
						if (limiter_zero_cross_disable) begin
							// One step each sample, applied at once
							next_tgt_l = atten(tgt_l, 4'h1);
							next_tgt_r = next_tgt_l;
							next_gl = next_tgt_l;
							next_gr = next_tgt_l;
						end else if (settled) begin
							// Wait for the last step to land so steps do not pile up
							next_tgt_l = atten(tgt_l, 4'h1 << limiter_atten_step);
							next_tgt_r = next_tgt_l;
							zc_restart = 1'b1;
						end
					end else if (peak >= level(limiter_threshold_sel, 1'b1)) begin
						next_wait_cnt = 15'h0000;
					end else begin
						// A limiter hit gone within one sample is taken as impulse noise
						if (hit)
							next_fast = 1'b1;
						if (wait_cnt < wait_len - 15'h0001) begin
							next_wait_cnt = wait_cnt + 15'h0001;
						end else if (settled) begin
							next_wait_cnt = 15'h0000;
							next_tgt_l = recover(tgt_l, recovery_max_gain,
								recovery_gain_step);
							next_tgt_r = next_tgt_l;
							zc_restart = 1'b1;
							if (next_tgt_l >= clamp(recovery_max_gain))
								next_fast = 1'b0;
						end
					end
				end
			end
		endcase
		if (!adc_on) begin
			next_state = ST_DOWN;
			next_wait_cnt = 15'h0000;
			next_init_cnt = 10'h000;
			next_fast = 1'b0;
			next_hit = 1'b0;
		end
		next_auto_active = (next_state == ST_AUTO);
	end

	// Register all state; outputs come straight from these flops
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_DOWN;
			left_input_gain <= `ALCIVC_GAIN_RESET;
			right_input_gain <= `ALCIVC_GAIN_RESET;
			tgt_l <= `ALCIVC_GAIN_RESET;
			tgt_r <= `ALCIVC_GAIN_RESET;
			left_gain_applied <= `ALCIVC_GAIN_RESET;
			right_gain_applied <= `ALCIVC_GAIN_RESET;
			wait_cnt <= 15'h0000;
			init_cnt <= 10'h000;
			fast <= 1'b0;
			hit <= 1'b0;
			auto_active <= 1'b0;
			fast_recovery_active <= 1'b0;
			reg_rdata <= 8'h00;
		end else begin
			state <= next_state;
			left_input_gain <= next_left_input_gain;
			right_input_gain <= next_right_input_gain;
			tgt_l <= next_tgt_l;
			tgt_r <= next_tgt_r;
			left_gain_applied <= next_gl;
			right_gain_applied <= next_gr;
			wait_cnt <= next_wait_cnt;
			init_cnt <= next_init_cnt;
			fast <= next_fast;
			hit <= next_hit;
			auto_active <= next_auto_active;
			fast_recovery_active <= next_fast;
			reg_rdata <= next_rdata;
		end
	end

	// Checks on the level-control and volume behaviour
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	logic live;
	assign live = adc_on && auto_level_enable && (state == ST_AUTO) && fs_tick;
	property p_limit_step;
		live && peak >= level(limiter_threshold_sel, 1'b0) && limiter_zero_cross_disable
			&& tgt_l > 8'h01 |=> tgt_l == $past(tgt_l) - 8'h01 && left_gain_applied == tgt_l
			&& right_gain_applied == tgt_l;
	endproperty
	a_limit_step: assert property (p_limit_step) else $error("limiter step wrong");
	property p_recover_cap;
		state == ST_AUTO && $past(state) == ST_AUTO && tgt_l > $past(tgt_l)
			|-> tgt_l <= clamp(recovery_max_gain);
	endproperty
	a_recover_cap: assert property (p_recover_cap) else $error("gain above max");
	property p_wait_reset;
		live && peak < level(limiter_threshold_sel, 1'b0)
			&& peak >= level(limiter_threshold_sel, 1'b1) |=> wait_cnt == 15'h0000;
	endproperty
	a_wait_reset: assert property (p_wait_reset) else $error("wait not cleared");
	property p_wait_run;
		live && peak < level(limiter_threshold_sel, 1'b1) && wait_cnt < wait_len - 15'h0001
			|=> wait_cnt == $past(wait_cnt) + 15'h0001;
	endproperty
	a_wait_run: assert property (p_wait_run) else $error("wait not counting");
	property p_manual_hold;
		state == ST_MANUAL && adc_on && !cross_l && !zc_timeout
			|=> $stable(left_gain_applied);
	endproperty
	a_manual_hold: assert property (p_manual_hold) else $error("gain moved early");
	property p_init_load;
		state == ST_INIT && next_state == ST_MANUAL |=> left_gain_applied ==
			clamp($past(left_input_gain)) ##1 state == ST_MANUAL || !adc_on;
	endproperty
	a_init_load: assert property (p_init_load) else $error("init load wrong");
	property p_gain_range;
		left_gain_applied <= `ALCIVC_GAIN_MAX && right_gain_applied <= `ALCIVC_GAIN_MAX;
	endproperty
	a_gain_range: assert property (p_gain_range) else $error("gain code out of range");
	property p_write_restart;
		state == ST_MANUAL && adc_on && !auto_level_enable && left_changed |-> zc_restart
			##1 left_input_gain == $past(reg_wdata);
	endproperty
	a_write_restart: assert property (p_write_restart) else $error("no restart");
	property p_same_write;
		state == ST_MANUAL && adc_on && !auto_level_enable && reg_wr
			&& reg_addr == `ALCIVC_LEFT_GAIN_ADDR && reg_wdata == left_input_gain |-> !zc_restart;
	endproperty
	a_same_write: assert property (p_same_write) else $error("same write restarted");
	property p_auto_start;
		state == ST_MANUAL && adc_on && auto_level_enable
			|=> tgt_l == clamp($past(left_input_gain)) && tgt_r == tgt_l;
	endproperty
	a_auto_start: assert property (p_auto_start) else $error("bad start value");
	property p_power_down;
		!adc_on |=> state == ST_DOWN && wait_cnt == 15'h0000 && !auto_active;
	endproperty
	a_power_down: assert property (p_power_down) else $error("not cleared");
	c_limit: cover property (live && peak >= level(limiter_threshold_sel, 1'b0));
	c_recover: cover property (state == ST_AUTO && tgt_l > $past(tgt_l));
	c_fast: cover property ($rose(fast));
	c_manual: cover property (state == ST_MANUAL && cross_l && tgt_l != left_gain_applied);
endmodule // alcivc_level_ctrl

//--- verification/alcivc_host_model.sv
// Host and sample-source model: fs ticks, test samples, register writes
`timescale 1ns/10ps
module alcivc_host_model #(
	parameter int FS_DIV = 2
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Sample stream
	output logic fs_tick,
	output alcivc_pkg::alcivc_sample_t left_sample,
	output alcivc_pkg::alcivc_sample_t right_sample,
	// Register port
	output logic reg_wr,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	import alcivc_pkg::*;
	// Knobs the bench sets: magnitude and whether the sign swings
	alcivc_sample_t amp;
	logic swing;
	logic neg;
	int div;

	initial begin
		amp = 16'h0100;
		swing = 1'b1;
		neg = 1'b0;
		div = 0;
		fs_tick = 1'b0;
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end

	// One tick per sample period; a swinging sign gives a crossing each tick
	always @(posedge sys_clk) begin
		div <= (div == FS_DIV - 1) ? 0 : div + 1;
		fs_tick <= arst_n && (div == 0);
		if (div == 0 && swing) begin
			neg <= !neg;
		end
	end

	assign left_sample = neg ? -amp : amp;
	assign right_sample = neg ? -amp : amp;

	// Register write: one strobe cycle, fields held with it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// Read: data follows the offset by one registered cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		repeat (2) @(posedge sys_clk);
		#1;
		d = reg_rdata;
	endtask
endmodule // alcivc_host_model

//--- verification/alc_input_volume_control_tb.sv
// Self-checking bench for the level control and input volume block
`timescale 1ns/10ps
module alc_input_volume_control_tb;
	import alcivc_pkg::*;
	localparam int FS_DIV = 2;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic fs_tick;
	alcivc_sample_t left_sample;
	alcivc_sample_t right_sample;
	logic left_adc_power = 1'b0;
	logic right_adc_power = 1'b0;
	logic auto_level_enable = 1'b0;
	logic [1:0] limiter_threshold_sel = 2'h0;
	logic [1:0] limiter_atten_step = 2'h0;
	logic [2:0] recovery_wait_sel = 3'h0; // Wait no shorter than the timeout
	logic [1:0] zero_cross_timeout_sel = 2'h0;
	logic [1:0] recovery_gain_step = 2'h0;
	alcivc_gain_t recovery_max_gain = 8'hf1;
	logic limiter_zero_cross_disable = 1'b0;
	logic [1:0] fast_recovery_speed = 2'h0;
	logic reg_wr;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	alcivc_gain_t left_gain_applied;
	alcivc_gain_t right_gain_applied;
	logic auto_active;
	logic fast_recovery_active;
	int bad_count = 0;
	int comparisons = 0;
	logic [7:0] d;
	logic [7:0] g;

	// 125 MHz clock
	always #4 sys_clk = !sys_clk;

	alcivc_level_ctrl i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .fs_tick(fs_tick),
		.left_sample(left_sample), .right_sample(right_sample),
		.left_adc_power(left_adc_power), .right_adc_power(right_adc_power),
		.auto_level_enable(auto_level_enable), .limiter_threshold_sel(limiter_threshold_sel),
		.limiter_atten_step(limiter_atten_step), .recovery_wait_sel(recovery_wait_sel),
		.zero_cross_timeout_sel(zero_cross_timeout_sel),
		.recovery_gain_step(recovery_gain_step), .recovery_max_gain(recovery_max_gain),
		.limiter_zero_cross_disable(limiter_zero_cross_disable),
		.fast_recovery_speed(fast_recovery_speed), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .left_gain_applied(left_gain_applied),
		.right_gain_applied(right_gain_applied), .auto_active(auto_active),
		.fast_recovery_active(fast_recovery_active));

	alcivc_host_model #(.FS_DIV(FS_DIV)) i_host (.sys_clk(sys_clk), .arst_n(arst_n),
		.fs_tick(fs_tick), .left_sample(left_sample), .right_sample(right_sample),
		.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk8(input logic [7:0] e, input logic [7:0] v);
		comparisons++;
		if (v !== e) begin
			bad_count++;
			$display("unexpected at %0t: expected %h got %h", $time, e, v);
		end
	endtask

	task automatic ticks(input int n);
		repeat (n * FS_DIV) @(posedge sys_clk);
		#1;
	endtask

	function automatic logic [7:0] gain_of(input logic sel);
		return sel ? right_gain_applied : left_gain_applied;
	endfunction

	// Waits for the applied gain to move, then checks the first new code
	task automatic wait_gain(input logic sel, input logic [7:0] e, input int n);
		logic [7:0] s;
		int k;
		#1;
		s = gain_of(sel);
		k = 0;
		while (gain_of(sel) === s && k < n * FS_DIV) begin
			@(posedge sys_clk);
			#1;
			k++;
		end
		chk8(e, gain_of(sel));
	endtask

	// Amplitude changes land on a clock edge
	task automatic set_amp(input alcivc_sample_t a);
		@(posedge sys_clk);
		i_host.amp <= a;
	endtask

	// Hang guard, well beyond the few thousand ticks the tests need
	initial begin
		#320000;
		bad_count++;
		complete_run();
	end

	initial begin
		repeat (8) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		#1;
		chk8(8'he1, left_gain_applied);
		chk8(8'h00, {7'h00, auto_active});
		i_host.rd(8'h0c, d);
		chk8(8'he1, d);
		i_host.rd(8'h33, d);
		chk8(8'h00, d);
		// Gain written while powered down waits for the end of init
		i_host.wr(8'h09, 8'h91);
		@(posedge sys_clk);
		right_adc_power <= 1'b1;
		ticks(60);
		chk8(8'he1, left_gain_applied);
		wait_gain(1'b0, 8'h91, 12);
		chk8(8'he1, right_gain_applied);
		// Manual mode: crossing, then timeout, restart and repeated value
		i_host.wr(8'h09, 8'hc0);
		wait_gain(1'b0, 8'hc0, 4);
		i_host.swing <= 1'b0;
		i_host.wr(8'h0c, 8'h80);
		ticks(120);
		chk8(8'he1, right_gain_applied);
		wait_gain(1'b1, 8'h80, 12);
		i_host.wr(8'h0c, 8'h70);
		ticks(100);
		i_host.wr(8'h0c, 8'h60);
		ticks(100);
		chk8(8'h80, right_gain_applied);
		wait_gain(1'b1, 8'h60, 40);
		i_host.wr(8'h0c, 8'h50);
		ticks(100);
		i_host.wr(8'h0c, 8'h50);
		wait_gain(1'b1, 8'h50, 40);
		// Level control starts from the left gain and recovers to the cap
		i_host.swing <= 1'b1;
		i_host.wr(8'h09, 8'h40);
		wait_gain(1'b0, 8'h40, 4);
		@(posedge sys_clk);
		recovery_max_gain <= 8'h46;
		recovery_gain_step <= 2'h1;
		auto_level_enable <= 1'b1;
		@(posedge sys_clk);
		#1;
		chk8(8'h01, {7'h00, auto_active});
		wait_gain(1'b1, 8'h40, 10);
		ticks(100);
		chk8(8'h40, left_gain_applied);
		wait_gain(1'b0, 8'h42, 40);
		set_amp(16'h5000);
		ticks(300);
		chk8(8'h42, left_gain_applied);
		set_amp(16'h0100);
		wait_gain(1'b0, 8'h44, 140);
		wait_gain(1'b0, 8'h46, 140);
		ticks(300);
		chk8(8'h46, left_gain_applied);
		chk8(8'h46, right_gain_applied);
		// Fields only change with level control off; gains fall back to the registers
		@(posedge sys_clk);
		auto_level_enable <= 1'b0;
		wait_gain(1'b1, 8'h50, 4);
		chk8(8'h40, left_gain_applied);
		@(posedge sys_clk);
		limiter_zero_cross_disable <= 1'b1;
		fast_recovery_speed <= 2'h1;
		ticks(140);
		@(posedge sys_clk);
		auto_level_enable <= 1'b1;
		// Immediate limiter steps one code, then an impulse gives 8x fast recovery
		set_amp(16'h6000);
		wait_gain(1'b0, 8'h3f, 6);
		set_amp(16'h0100);
		ticks(4);
		chk8(8'h01, {7'h00, fast_recovery_active});
		g = left_gain_applied;
		wait_gain(1'b0, g + 8'h02, 20);
		// Zero-cross limiter with an eight-code step, after another pause
		@(posedge sys_clk);
		auto_level_enable <= 1'b0;
		@(posedge sys_clk);
		limiter_zero_cross_disable <= 1'b0;
		limiter_atten_step <= 2'h3;
		ticks(140);
		@(posedge sys_clk);
		auto_level_enable <= 1'b1;
		set_amp(16'h6000);
		wait_gain(1'b0, 8'h38, 10);
		set_amp(16'h5000);
		ticks(4);
		// Writes in level control are held back until it is switched off
		g = left_gain_applied;
		i_host.wr(8'h09, 8'h20);
		ticks(140);
		chk8(g, left_gain_applied);
		@(posedge sys_clk);
		auto_level_enable <= 1'b0;
		wait_gain(1'b0, 8'h20, 140);
		ticks(2);
		chk8(8'h50, right_gain_applied);
		chk8(8'h00, {7'h00, auto_active});
		complete_run();
	end
endmodule // alc_input_volume_control_tb
